/* hw/ppg_cfg.svh */
// Constants for the peripheral power gate block.
// Assumes inclusion by the package and the design modules only.
`ifndef PPG_CFG_SVH
`define PPG_CFG_SVH
`define PPG_NUM_MODULES 8
`define PPG_DATA_W 8
`define PPG_ADDR_W 4
`define PPG_CTRL_RESET 8'h00
`define PPG_READ_ZERO 8'h00
`define PPG_SYSCLK_BIT 0
// One instruction cycle of the core, counted in system clocks
`define PPG_SETTLE_CYCLES 4
`endif

/* hw/ppg_pkg.sv */
// Types for the peripheral power gate block.
// Assumes ppg_cfg.svh is on the include path.
`include "ppg_cfg.svh"
package ppg_pkg;
  typedef enum logic [1:0] {
    PPG_ON = 2'b00,
    PPG_OFF = 2'b01,
    PPG_SETTLE = 2'b10
  } ppg_state_t;
endpackage

/* hw/ppg_slot.sv */
// One gated module slot: reset hold, clock enable, bus and output masking.
// Assumes the disable level arrives registered from the top module.
`timescale 1ns/1ns
`include "ppg_cfg.svh"
module ppg_slot
  import ppg_pkg::*;
#(
  parameter int DATA_W = `PPG_DATA_W,
  parameter int SETTLE = `PPG_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic disable_in,
  input wire logic sys_gate_off,
  input wire logic uses_sysclk,
  input wire logic wr_req,
  input wire logic [DATA_W-1:0] rd_from_mod,
  input wire logic dout_from_mod,
  input wire logic aout_from_mod,
  output logic clk_en_r,
  output logic mod_rst_n_r,
  output logic wr_pass_r,
  output logic [DATA_W-1:0] rd_data_r,
  output logic dout_r,
  output logic aout_en_r,
  output logic active_r
);
  ppg_state_t state_r;
  logic [3:0] cnt_r;

  // Settle phase keeps active_r low after release from reset; bus and outputs are not masked
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= PPG_ON;
      cnt_r <= 4'h0;
    end else begin
      unique case (state_r)
        PPG_ON: begin
          if (disable_in) begin
            state_r <= PPG_OFF;
          end
        end
        PPG_OFF: begin
          if (!disable_in) begin
            state_r <= PPG_SETTLE;
            cnt_r <= 4'h0;
          end
        end
        PPG_SETTLE: begin
          if (disable_in) begin
            state_r <= PPG_OFF;
          end else if (cnt_r == 4'(SETTLE - 1)) begin
            state_r <= PPG_ON;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        default: state_r <= PPG_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_en_r <= 1'b1;
      mod_rst_n_r <= 1'b1;
      active_r <= 1'b1;
    end else begin
      // Clock gate enable is a registered level, so an ICG stays glitch-free
      clk_en_r <= !disable_in && !(sys_gate_off && uses_sysclk);
      mod_rst_n_r <= !disable_in;
      active_r <= !disable_in && (state_r == PPG_ON);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pass_r <= 1'b0;
      rd_data_r <= DATA_W'(`PPG_READ_ZERO);
      dout_r <= 1'b0;
      aout_en_r <= 1'b0;
    end else begin
      wr_pass_r <= wr_req && !disable_in;
      rd_data_r <= disable_in ? DATA_W'(`PPG_READ_ZERO) : rd_from_mod;
      dout_r <= !disable_in && dout_from_mod;
      aout_en_r <= !disable_in && aout_from_mod;
    end
  end

  rst_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    disable_in |=> !mod_rst_n_r && !clk_en_r)
    else $error("module not held in reset while disabled");
  out_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
    disable_in |=> (rd_data_r == '0) && !dout_r && !aout_en_r && !wr_pass_r)
    else $error("disabled module leaks data");
  settle_time_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(disable_in) ##1 !disable_in [*4] |-> !active_r)
    else $error("module active before settle");
  settle_end_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(disable_in) ##0 !disable_in [*7] |-> active_r)
    else $error("module not active after settle");
  off_cov: cover property (@(posedge clk) disable iff (!arst_n) $rose(disable_in));
  back_cov: cover property (@(posedge clk) disable iff (!arst_n) $rose(active_r));
endmodule

/* hw/ppg_top.sv */
// Peripheral power gate: per-module disable levels driving gated slots.
// Assumes the core presents write strobes synchronous to clk.
`timescale 1ns/1ns
`include "ppg_cfg.svh"
module ppg_top
  import ppg_pkg::*;
#(
  parameter int NUM = `PPG_NUM_MODULES,
  parameter int DATA_W = `PPG_DATA_W,
  parameter int SETTLE = `PPG_SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ctrl_wr,
  input wire logic [NUM-1:0] ctrl_wdata,
  input wire logic sys_gate_wr,
  input wire logic sys_gate_wdata,
  input wire logic [NUM-1:0] uses_sysclk,
  input wire logic [NUM-1:0] wr_req,
  input wire logic [NUM*DATA_W-1:0] rd_from_mod,
  input wire logic [NUM-1:0] dout_from_mod,
  input wire logic [NUM-1:0] aout_from_mod,
  output logic [NUM-1:0] peripheral_power_gate_r,
  output logic system_clock_gate_off_r,
  output logic [NUM-1:0] clk_en_r,
  output logic [NUM-1:0] mod_rst_n_r,
  output logic [NUM-1:0] wr_pass_r,
  output logic [NUM*DATA_W-1:0] rd_data_r,
  output logic [NUM-1:0] dout_r,
  output logic [NUM-1:0] aout_en_r,
  output logic [NUM-1:0] active_r
);
  // Disable levels; the readback outputs are these very flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      peripheral_power_gate_r <= NUM'(`PPG_CTRL_RESET);
    end else if (ctrl_wr) begin
      peripheral_power_gate_r <= ctrl_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      system_clock_gate_off_r <= 1'b0;
    end else if (sys_gate_wr) begin
      system_clock_gate_off_r <= sys_gate_wdata;
    end
  end

  // Software is trusted to leave a slot alone while active_r is low
  genvar g;
  generate
    for (g = 0; g < NUM; g++) begin : g_slot
      ppg_slot #(.DATA_W(DATA_W), .SETTLE(SETTLE)) u_slot (
        .clk(clk),
        .arst_n(arst_n),
        .disable_in(peripheral_power_gate_r[g]),
        .sys_gate_off(system_clock_gate_off_r),
        .uses_sysclk(uses_sysclk[g]),
        .wr_req(wr_req[g]),
        .rd_from_mod(rd_from_mod[g*DATA_W +: DATA_W]),
        .dout_from_mod(dout_from_mod[g]),
        .aout_from_mod(aout_from_mod[g]),
        .clk_en_r(clk_en_r[g]),
        .mod_rst_n_r(mod_rst_n_r[g]),
        .wr_pass_r(wr_pass_r[g]),
        .rd_data_r(rd_data_r[g*DATA_W +: DATA_W]),
        .dout_r(dout_r[g]),
        .aout_en_r(aout_en_r[g]),
        .active_r(active_r[g])
      );
    end
  endgenerate

  ctrl_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    ctrl_wr |=> peripheral_power_gate_r == $past(ctrl_wdata))
    else $error("disable control not written");
  ctrl_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !ctrl_wr |=> $stable(peripheral_power_gate_r))
    else $error("disable control changed without write");
  sysclk_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    (system_clock_gate_off_r && uses_sysclk[0]) |=> !clk_en_r[0])
    else $error("sysclk user still clocked");
  gate_timing_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ctrl_wr && ctrl_wdata[0] && !system_clock_gate_off_r) ##1 1'b1
      |=> !clk_en_r[0])
    else $error("gate late after write");
  sys_cov: cover property (@(posedge clk) disable iff (!arst_n)
    $rose(system_clock_gate_off_r));
  all_off_cov: cover property (@(posedge clk) disable iff (!arst_n)
    &peripheral_power_gate_r);
endmodule

/* tb/ppg_periph_model.sv */
// Gated peripheral stand-ins: one data byte per slot, outputs held active.
// Assumes the slot outputs of ppg_top drive its inputs directly.
`timescale 1ns/1ns
module ppg_periph_model #(
  parameter int NUM = 8
) (
  input wire logic clk,
  input wire logic [NUM-1:0] clk_en_r,
  input wire logic [NUM-1:0] mod_rst_n_r,
  input wire logic [NUM-1:0] wr_pass_r,
  output logic [NUM*8-1:0] rd_from_mod,
  output logic [NUM-1:0] dout_from_mod,
  output logic [NUM-1:0] aout_from_mod
);
  // Outputs stay high even when gated, so only the block's masking hides them
  assign dout_from_mod = '1;
  assign aout_from_mod = '1;
  always_ff @(posedge clk) begin
    for (int g = 0; g < NUM; g++) begin
      if (!mod_rst_n_r[g]) begin
        rd_from_mod[g*8+:8] <= 8'hA0;
      end else if (clk_en_r[g] && wr_pass_r[g]) begin
        rd_from_mod[g*8+:8] <= 8'h5C;
      end
    end
  end
endmodule

/* tb/tb_peripheral_module_disable.sv */
// Directed bench for ppg_top with the peripheral stand-in model.
// Assumes inputs change at the falling edge only.
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t value %h", $time, (a)); end end
module tb_peripheral_module_disable;
  import ppg_pkg::*;
  localparam int NUM = 8;
  localparam int SETTLE = 4;
  logic clk = 0, arst_n = 0, ctrl_wr = 0, sys_gate_wr = 0, sys_gate_wdata = 0, sys_off;
  logic [NUM-1:0] ctrl_wdata = '0, uses_sysclk = '0, wr_req = '0;
  logic [NUM-1:0] gate, clk_en, rst_n, wr_pass, dout, aout, active, dout_m, aout_m;
  logic [NUM*8-1:0] rd_m, rd_data;
  int errors = 0;
  int cmp_count = 0;
  ppg_top #(.NUM(NUM), .DATA_W(8), .SETTLE(SETTLE)) dut (.clk(clk), .arst_n(arst_n),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .sys_gate_wr(sys_gate_wr),
    .sys_gate_wdata(sys_gate_wdata), .uses_sysclk(uses_sysclk), .wr_req(wr_req),
    .rd_from_mod(rd_m), .dout_from_mod(dout_m), .aout_from_mod(aout_m),
    .peripheral_power_gate_r(gate), .system_clock_gate_off_r(sys_off), .clk_en_r(clk_en),
    .mod_rst_n_r(rst_n), .wr_pass_r(wr_pass), .rd_data_r(rd_data), .dout_r(dout),
    .aout_en_r(aout), .active_r(active));
  ppg_periph_model #(.NUM(NUM)) model (.clk(clk), .clk_en_r(clk_en), .mod_rst_n_r(rst_n),
    .wr_pass_r(wr_pass), .rd_from_mod(rd_m), .dout_from_mod(dout_m), .aout_from_mod(aout_m));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic put_ctrl(logic [NUM-1:0] v);
    ctrl_wr = 1;
    ctrl_wdata = v;
    tick(1);
    ctrl_wr = 0;
    tick(1);
    `CHK(gate, v)
    tick(1);
  endtask
  task automatic t_reset();
    `CHK(gate, 8'h00)
    `CHK(sys_off, 1'b0)
    `CHK(clk_en & rst_n & active, 8'hFF)
    $display("t_reset done");
  endtask
  task automatic t_off();
    put_ctrl(8'h05);
    `CHK(clk_en, 8'hFA)
    `CHK(rst_n, 8'hFA)
    `CHK(dout & aout, 8'hFA)
    `CHK(rd_data[7:0], 8'h00)
    wr_req = 8'h03;
    tick(1);
    wr_req = 8'h00;
    `CHK(wr_pass, 8'h02)
    tick(2);
    `CHK(rd_data[15:0], 16'h5C00)
    $display("t_off done");
  endtask
  task automatic t_on();
    int n;
    put_ctrl(8'h00);
    `CHK(rst_n, 8'hFF)
    `CHK(active[0], 1'b0)
    tick(1);
    `CHK(rd_data[7:0], 8'hA0)
    n = 0;
    while (active[0] !== 1'b1 && n < SETTLE + 4) begin
      tick(1);
      n++;
    end
    `CHK(active[0], 1'b1)
    if (n == SETTLE + 4) begin
      close_out();
    end
    // Only touch the module once it reports active
    wr_req = 8'h01;
    tick(1);
    wr_req = 8'h00;
    `CHK(wr_pass[0], 1'b1)
    $display("t_on done");
  endtask
  task automatic t_sys(logic v, logic [NUM-1:0] en);
    uses_sysclk = 8'h0F;
    sys_gate_wr = 1;
    sys_gate_wdata = v;
    tick(1);
    sys_gate_wr = 0;
    tick(2);
    `CHK(sys_off, v)
    `CHK(clk_en, en)
    $display("t_sys done");
  endtask
  task automatic t_rst();
    put_ctrl(8'hFF);
    arst_n = 0;
    tick(1);
    `CHK(gate, 8'h00)
    `CHK(clk_en & rst_n, 8'hFF)
    arst_n = 1;
    tick(1);
    $display("t_rst done");
  endtask
  initial begin
    tick(16);
    arst_n = 1;
    tick(1);
    t_reset();
    t_off();
    t_on();
    t_sys(1'b1, 8'hF0);
    t_sys(1'b0, 8'hFF);
    t_rst();
    close_out();
  end
endmodule
